// ===== common/spi_serial_pkg.sv
package spi_serial_pkg;

	// shift register width and byte length
	localparam int SHIFT_W = 16;
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] BIT_CNT_LAST = 4'h7;

	// prescaler: shift clock half period in system clocks
	localparam int PRESCALE_W = 8;
	localparam logic [7:0] PRESCALE_RST = 8'h01;

	// reset values
	localparam logic [15:0] SHIFT_RST = 16'h0000;

	// configuration bits gathered in one struct
	typedef struct packed {
		logic port_enable_bit;
		logic master_mode;
		logic clk_polarity;
		logic clk_phase;
		logic slave_sel_enable;
		logic out_pin_release_bit;
		logic frame_mode_enable;
		logic xfer_done_irq_enable;
	} serial_control_t;

	// pin directions and levels
	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic sdo_o;
		logic sdo_oe;
		logic fs_o;
		logic fs_oe;
		logic ss_own;
	} pin_drive_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LEAD = 2'b01,
		ST_TRAIL = 2'b10
	} xfer_state_t;

endpackage

// ===== hdl/spi_prescaler.sv
`timescale 1ns/10ps
`default_nettype none

module spi_prescaler #(
	parameter int WIDTH = spi_serial_pkg::PRESCALE_W
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic run_i,
	input wire logic [WIDTH-1:0] div_i,
	output logic tick_o
);

	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;
	logic tick_d;

	// counts div_i+1 system clocks per tick; held at zero when idle so the
	// first edge of a transfer is always one full half period away
	always_comb begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (!run_i) begin
			cnt_d = '0;
		end else if (cnt_q == div_i) begin
			cnt_d = '0;
			tick_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_o <= tick_d;
		end
	end

endmodule

`default_nettype wire

// ===== hdl/spi_serial_port.sv
`timescale 1ns/10ps
`default_nettype none

module spi_serial_port #(
	parameter int PRESCALE_W = spi_serial_pkg::PRESCALE_W
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire spi_serial_pkg::serial_control_t ctrl_i,
	input wire logic [PRESCALE_W-1:0] prescale_i,
	input wire logic wr_i,
	input wire logic [15:0] wdata_i,
	input wire logic done_clr_i,
	output logic [15:0] serial_buffer_reg_o,
	output logic xfer_done_flag_o,
	output logic irq_o,
	output logic busy_o,
	input wire logic serial_in_pin_i,
	input wire logic sck_pin_i,
	input wire logic slave_sel_n_pin_i,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe_o,
	output logic sck_pin_o,
	output logic sck_pin_oe_o,
	output logic frame_pulse_pin_o,
	output logic frame_pulse_pin_oe_o,
	output logic slave_sel_owned_o
);

	////////////////////////////////////////////////////////////////////////
	// state

	spi_serial_pkg::xfer_state_t state_q, state_d;
	logic [15:0] serial_shift_reg_q, serial_shift_reg_d;
	logic [15:0] buf_q, buf_d;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	logic sck_lvl_q, sck_lvl_d;
	logic sck_in_q;
	logic done_q, done_d;
	logic in_bit_q, in_bit_d;
	logic fs_q, fs_d;
	logic tick;
	logic run;
	logic en;
	logic master;
	logic sel_ok;
	logic lead_edge;
	logic trail_edge;
	logic cpha;
	logic ext_rise;
	logic ext_fall;
	logic ext_lead;
	logic ext_trail;
	logic done_set;
	spi_serial_pkg::pin_drive_t pins;

	assign en = ctrl_i.port_enable_bit;
	assign master = ctrl_i.master_mode;
	assign cpha = ctrl_i.clk_phase;
	// slave select gates slave traffic only
	assign sel_ok = master || !ctrl_i.slave_sel_enable || !slave_sel_n_pin_i;
	assign run = en && master && (state_q != spi_serial_pkg::ST_IDLE);

	spi_prescaler #(
		.WIDTH(PRESCALE_W)
	) u_prescaler (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.run_i(run),
		.div_i(prescale_i),
		.tick_o(tick)
	);

	////////////////////////////////////////////////////////////////////////
	// edge detection of the external shift clock (pins are synchronous)

	assign ext_rise = sck_pin_i && !sck_in_q;
	assign ext_fall = !sck_pin_i && sck_in_q;
	// leading edge leaves the idle level set by polarity
	assign ext_lead = ctrl_i.clk_polarity ? ext_fall : ext_rise;
	assign ext_trail = ctrl_i.clk_polarity ? ext_rise : ext_fall;

	// in slave mode sampling uses ext edges; in master mode prescaler ticks
	assign lead_edge = master ? (tick && state_q == spi_serial_pkg::ST_LEAD)
		: (ext_lead && sel_ok);
	assign trail_edge = master ? (tick && state_q == spi_serial_pkg::ST_TRAIL)
		: (ext_trail && sel_ok);

	////////////////////////////////////////////////////////////////////////
	// transfer engine

	always_comb begin
		state_d = state_q;
		serial_shift_reg_d = serial_shift_reg_q;
		buf_d = buf_q;
		bit_cnt_d = bit_cnt_q;
		sck_lvl_d = sck_lvl_q;
		in_bit_d = in_bit_q;
		fs_d = 1'b0;
		done_set = 1'b0;
		if (!en) begin
			state_d = spi_serial_pkg::ST_IDLE;
			bit_cnt_d = '0;
			sck_lvl_d = ctrl_i.clk_polarity;
		end else if (wr_i) begin
			serial_shift_reg_d = wdata_i;
			buf_d = wdata_i;
			bit_cnt_d = '0;
			sck_lvl_d = ctrl_i.clk_polarity;
			state_d = spi_serial_pkg::ST_LEAD;
			fs_d = ctrl_i.frame_mode_enable && master;
		end else begin
			case (state_q)
				spi_serial_pkg::ST_IDLE: begin
					sck_lvl_d = ctrl_i.clk_polarity;
					// slave waits armed for the other party's clock
					if (!master) begin
						state_d = spi_serial_pkg::ST_LEAD;
					end
				end
				spi_serial_pkg::ST_LEAD: begin
					if (lead_edge) begin
						if (master) begin
							sck_lvl_d = !ctrl_i.clk_polarity;
						end
						state_d = spi_serial_pkg::ST_TRAIL;
						if (!cpha) begin
							in_bit_d = serial_in_pin_i;
							done_set = (bit_cnt_q == spi_serial_pkg::BIT_CNT_LAST);
						end else if (bit_cnt_q != 4'h0) begin
							// phase 1: the first leading edge must leave bit 7 on the line
							serial_shift_reg_d = {serial_shift_reg_q[14:0], in_bit_q};
						end
					end
				end
				spi_serial_pkg::ST_TRAIL: begin
					if (trail_edge) begin
						if (master) begin
							sck_lvl_d = ctrl_i.clk_polarity;
						end
						if (cpha) begin
							in_bit_d = serial_in_pin_i;
							done_set = (bit_cnt_q == spi_serial_pkg::BIT_CNT_LAST);
							// no leading edge follows the last sample, so fold it in here
							if (done_set) begin
								serial_shift_reg_d = {serial_shift_reg_q[14:0], serial_in_pin_i};
							end
						end else begin
							serial_shift_reg_d = {serial_shift_reg_q[14:0], in_bit_q};
						end
						if (bit_cnt_q == spi_serial_pkg::BIT_CNT_LAST) begin
							bit_cnt_d = '0;
							state_d = master ? spi_serial_pkg::ST_IDLE : spi_serial_pkg::ST_LEAD;
						end else begin
							bit_cnt_d = bit_cnt_q + 4'h1;
							state_d = spi_serial_pkg::ST_LEAD;
						end
					end
				end
				default: state_d = spi_serial_pkg::ST_IDLE;
			endcase
		end
		// the last bit is latched here; fold it in and hand the byte over
		if (done_set) begin
			buf_d = {8'h00, serial_shift_reg_q[6:0], serial_in_pin_i};
		end
		// the next shift of that bit must land in the shift register too
		done_d = (done_q && !done_clr_i) || done_set;
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= spi_serial_pkg::ST_IDLE;
			serial_shift_reg_q <= spi_serial_pkg::SHIFT_RST;
			buf_q <= spi_serial_pkg::SHIFT_RST;
			bit_cnt_q <= '0;
			sck_lvl_q <= 1'b0;
			sck_in_q <= 1'b0;
			done_q <= 1'b0;
			in_bit_q <= 1'b0;
			fs_q <= 1'b0;
		end else begin
			state_q <= state_d;
			serial_shift_reg_q <= serial_shift_reg_d;
			buf_q <= buf_d;
			bit_cnt_q <= bit_cnt_d;
			sck_lvl_q <= sck_lvl_d;
			sck_in_q <= sck_pin_i;
			done_q <= done_d;
			in_bit_q <= in_bit_d;
			fs_q <= fs_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin ownership and direction

	always_comb begin
		pins.sck_o = sck_lvl_d;
		pins.sck_oe = en && master;
		// with phase 0 the first bit must sit on the line before the first edge
		pins.sdo_o = serial_shift_reg_d[7];
		pins.sdo_oe = en && !ctrl_i.out_pin_release_bit
			&& (master || !ctrl_i.slave_sel_enable || !slave_sel_n_pin_i);
		pins.fs_o = fs_d;
		pins.fs_oe = en && ctrl_i.frame_mode_enable && master;
		pins.ss_own = en && !master && ctrl_i.slave_sel_enable;
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			serial_out_pin_o <= 1'b0;
			serial_out_pin_oe_o <= 1'b0;
			sck_pin_o <= 1'b0;
			sck_pin_oe_o <= 1'b0;
			frame_pulse_pin_o <= 1'b0;
			frame_pulse_pin_oe_o <= 1'b0;
			slave_sel_owned_o <= 1'b0;
			serial_buffer_reg_o <= spi_serial_pkg::SHIFT_RST;
			xfer_done_flag_o <= 1'b0;
			irq_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			serial_out_pin_o <= pins.sdo_o;
			serial_out_pin_oe_o <= pins.sdo_oe;
			sck_pin_o <= pins.sck_o;
			sck_pin_oe_o <= pins.sck_oe;
			frame_pulse_pin_o <= pins.fs_o;
			frame_pulse_pin_oe_o <= pins.fs_oe;
			slave_sel_owned_o <= pins.ss_own;
			serial_buffer_reg_o <= buf_d;
			xfer_done_flag_o <= done_d;
			irq_o <= done_d && ctrl_i.xfer_done_irq_enable;
			busy_o <= master ? (state_d != spi_serial_pkg::ST_IDLE) : (bit_cnt_d != 4'h0);
		end
	end

endmodule

`default_nettype wire

// ===== sim/spi_peer_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_peer_model (
	input wire logic clk_i,
	input wire logic sck_i,
	input wire logic sdo_i,
	input wire logic cpol_i,
	input wire logic cpha_i,
	output logic sdi_o,
	output logic sck_o,
	output logic ss_n_o,
	output logic [7:0] rx_o
);
	logic [7:0] tx_q;
	int shifts;
	int k;
	initial begin
		sck_o = 1'b0;
		ss_n_o = 1'b1;
		tx_q = 8'h00;
		shifts = 0;
		rx_o = 8'h00;
	end
	// sample on one edge kind, shift on the other, as the clock mode selects
	always @(sck_i) begin
		if (sck_i === (cpol_i == cpha_i))
			rx_o <= {rx_o[6:0], sdo_i};
		else
			shifts <= shifts + 1;
	end
	// outside the byte the line shows a wrong bit, not a held one
	always_comb begin
		k = shifts - int'(cpha_i);
		sdi_o = (k < 0 || k > 7) ? ~tx_q[0] : tx_q[7 - k];
	end
	task automatic load(input logic [7:0] b);
		tx_q = b;
		shifts = 0;
		rx_o = 8'h00;
	endtask
	task automatic clock_byte(input logic sel_n);
		ss_n_o <= sel_n;
		sck_o <= cpol_i;
		repeat (16) begin
			repeat (4) @(posedge clk_i);
			sck_o <= ~sck_o;
		end
		repeat (4) @(posedge clk_i);
		ss_n_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== sim/spi_serial_port_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module spi_serial_port_asserts #(
	parameter int PRESCALE_W = spi_serial_pkg::PRESCALE_W
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire spi_serial_pkg::serial_control_t ctrl_i,
	input wire logic [PRESCALE_W-1:0] prescale_i,
	input wire logic wr_i,
	input wire logic done_clr_i,
	input wire logic xfer_done_flag_o,
	input wire logic irq_o,
	input wire logic slave_sel_n_pin_i,
	input wire logic serial_out_pin_oe_o,
	input wire logic sck_pin_oe_o,
	input wire logic frame_pulse_pin_oe_o,
	input wire logic slave_sel_owned_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	logic [15:0] age_q;
	logic [15:0] age_d;
	// cycles since the last accepted write; saturates so a stale value never wraps
	always_comb begin
		age_d = (age_q == 16'hFFFF) ? age_q : age_q + 16'h0001;
		if (wr_i && ctrl_i.port_enable_bit)
			age_d = 16'h0000;
	end
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			age_q <= 16'hFFFF;
		else
			age_q <= age_d;
	end
	//////////////////////////////////////////
	a_done_timing: assert property ($rose(xfer_done_flag_o) && ctrl_i.master_mode
		|-> 32'(age_q) == (15 + 32'(ctrl_i.clk_phase)) * (32'(prescale_i) + 1) + 1)
		else $error("done flag late");
	a_flag_sticky: assert property ($past(xfer_done_flag_o) && !$past(done_clr_i)
		|-> xfer_done_flag_o) else $error("done flag lost");
	a_irq_gate: assert property (!$past(ctrl_i.xfer_done_irq_enable) |-> !irq_o)
		else $error("irq while masked");
	a_sck_owner: assert property (!$past(sys_rst_i) |-> sck_pin_oe_o ==
		$past(ctrl_i.port_enable_bit && ctrl_i.master_mode)) else $error("clock dir");
	a_sel_owner: assert property (!$past(sys_rst_i) |-> slave_sel_owned_o == $past(
		ctrl_i.port_enable_bit && !ctrl_i.master_mode && ctrl_i.slave_sel_enable))
		else $error("select owner");
	a_sdo_release: assert property (!$past(sys_rst_i) && $past(ctrl_i.out_pin_release_bit)
		|-> !serial_out_pin_oe_o) else $error("data out kept");
	a_sdo_deselect: assert property ((slave_sel_n_pin_i && ctrl_i.slave_sel_enable
		&& !ctrl_i.master_mode) [*3] |-> !serial_out_pin_oe_o) else $error("data out on");
	a_frame_owner: assert property (!$past(sys_rst_i) && !$past(ctrl_i.frame_mode_enable)
		|-> !frame_pulse_pin_oe_o) else $error("frame pin kept");
endmodule
bind spi_serial_port spi_serial_port_asserts #(.PRESCALE_W(PRESCALE_W)) i_chk (
	.clk_sys_i, .sys_rst_i, .ctrl_i, .prescale_i, .wr_i, .done_clr_i, .xfer_done_flag_o,
	.irq_o, .slave_sel_n_pin_i, .serial_out_pin_oe_o, .sck_pin_oe_o,
	.frame_pulse_pin_oe_o, .slave_sel_owned_o);
`default_nettype wire

// ===== sim/spi_serial_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
module spi_serial_port_bench;
	logic clk_sys_i, sys_rst_i, wr_i, done_clr_i, serial_in_pin_i, slave_sel_n_pin_i;
	spi_serial_pkg::serial_control_t ctrl_i;
	logic [7:0] prescale_i, peer_rx;
	logic [15:0] wdata_i, serial_buffer_reg_o;
	logic xfer_done_flag_o, irq_o, busy_o, serial_out_pin_o, serial_out_pin_oe_o;
	logic sck_pin_o, sck_pin_oe_o, frame_pulse_pin_o, frame_pulse_pin_oe_o;
	logic slave_sel_owned_o, peer_sck;
	int fails, checks;
	wire sck_pin_i = sck_pin_oe_o ? sck_pin_o : peer_sck;
	// released data line reads high through its pull-up
	wire sdo_line = serial_out_pin_oe_o ? serial_out_pin_o : 1'b1;
	spi_serial_port #(.PRESCALE_W(8)) i_dut (.clk_sys_i, .sys_rst_i, .ctrl_i, .prescale_i,
		.wr_i, .wdata_i, .done_clr_i, .serial_buffer_reg_o, .xfer_done_flag_o, .irq_o,
		.busy_o, .serial_in_pin_i, .sck_pin_i, .slave_sel_n_pin_i, .serial_out_pin_o,
		.serial_out_pin_oe_o, .sck_pin_o, .sck_pin_oe_o, .frame_pulse_pin_o,
		.frame_pulse_pin_oe_o, .slave_sel_owned_o);
	spi_peer_model i_peer (.clk_i(clk_sys_i), .sck_i(sck_pin_i), .sdo_i(sdo_line),
		.cpol_i(ctrl_i.clk_polarity), .cpha_i(ctrl_i.clk_phase), .sdi_o(serial_in_pin_i),
		.sck_o(peer_sck), .ss_n_o(slave_sel_n_pin_i), .rx_o(peer_rx));
	//////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic give_verdict;
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic put(input logic [15:0] d);
		@(posedge clk_sys_i);
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		@(negedge clk_sys_i);
	endtask
	task automatic clear;
		@(posedge clk_sys_i);
		done_clr_i <= 1'b1;
		@(posedge clk_sys_i);
		done_clr_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("flag", 16'(xfer_done_flag_o), 16'h0000);
	endtask
	task automatic setup(input logic [7:0] c, input logic [7:0] p, input logic [7:0] rx);
		@(posedge clk_sys_i);
		ctrl_i <= c;
		prescale_i <= p;
		repeat (3) @(posedge clk_sys_i);
		i_peer.load(rx);
	endtask
	task automatic run_master(input logic [1:0] md, input logic ie);
		int n;
		n = 0;
		setup({2'b11, md, 3'b000, ie}, 8'(md), 8'h96 ^ 8'(md));
		put({8'hC3, 8'h5A ^ 8'(md)});
		chk("buffer", serial_buffer_reg_o, {8'hC3, 8'h5A ^ 8'(md)});
		chk("busy", 16'(busy_o), 16'h0001);
		chk("out dir", 16'(serial_out_pin_oe_o), 16'h0001);
		while (xfer_done_flag_o !== 1'b1 && n < 200) begin
			@(negedge clk_sys_i);
			n++;
		end
		chk("rx", serial_buffer_reg_o, {8'h00, 8'h96 ^ 8'(md)});
		chk("peer rx", 16'(peer_rx), {8'h00, 8'h5A ^ 8'(md)});
		chk("irq", 16'(irq_o), 16'(ie));
		repeat (20) @(negedge clk_sys_i);
		chk("held", 16'(xfer_done_flag_o), 16'h0001);
		clear;
	endtask
	task automatic run_slave(input logic [1:0] md);
		setup({2'b10, md, 4'b1000}, 8'h00, 8'h3C);
		put(16'h00A5);
		i_peer.clock_byte(1'b1);
		@(negedge clk_sys_i);
		chk("ignored", 16'(xfer_done_flag_o), 16'h0000);
		chk("out off", 16'(serial_out_pin_oe_o), 16'h0000);
		chk("sel own", 16'(slave_sel_owned_o), 16'h0001);
		i_peer.load(8'h3C);
		i_peer.clock_byte(1'b0);
		@(negedge clk_sys_i);
		chk("done", 16'(xfer_done_flag_o), 16'h0001);
		chk("rx", serial_buffer_reg_o, 16'h003C);
		chk("peer rx", 16'(peer_rx), 16'h00A5);
		chk("clk dir", 16'(sck_pin_oe_o), 16'h0000);
		clear;
	endtask
	task automatic pins;
		setup(8'hC6, 8'h00, 8'h00);
		@(negedge clk_sys_i);
		chk("clk dir", 16'(sck_pin_oe_o), 16'h0001);
		chk("out rel", 16'(serial_out_pin_oe_o), 16'h0000);
		chk("frame", 16'(frame_pulse_pin_oe_o), 16'h0001);
		put(16'h0000);
		chk("pulse", 16'(frame_pulse_pin_o), 16'h0001);
		setup(8'h00, 8'h00, 8'h00);
		@(negedge clk_sys_i);
		chk("off", 16'(sck_pin_oe_o), 16'h0000);
	endtask
	//////////////////////////////////////////
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// the sequence needs several hundred cycles; the 30000-cycle limit leaves wide margin
	initial begin
		#3000000;
		fails++;
		give_verdict;
	end
	initial begin
		{sys_rst_i, wr_i, done_clr_i, ctrl_i, prescale_i, wdata_i} = {3'b100, 32'h0};
		fails = 0;
		checks = 0;
		repeat (10) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("reset buf", serial_buffer_reg_o, 16'h0000);
		for (int m = 0; m < 4; m++)
			run_master(2'(m), m[0]);
		run_slave(2'b00);
		run_slave(2'b11);
		pins;
		give_verdict;
	end
endmodule
`default_nettype wire
